// *** verilog/mrs_map.svh ***
// Purpose: constants of the microprogram repeat sequencer
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef MRS_MAP_SVH
`define MRS_MAP_SVH

// ----------------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------------
`define MRS_ADDR_W   8
`define MRS_CTRL_W   16
`define MRS_CNT_W    4

// ----------------------------------------------------------------------------
// counter values
// ----------------------------------------------------------------------------
`define MRS_CNT_FULL 4'hF
`define MRS_CNT_ONE  4'h1
`define MRS_CNT_RST  4'hF

// ----------------------------------------------------------------------------
// reset values and the address increment
// ----------------------------------------------------------------------------
`define MRS_UPC_RST  8'h00
`define MRS_SAVE_RST 8'h00
`define MRS_CTRL_RST 16'h0000
`define MRS_ADDR_ONE 8'h01

`endif

// *** verilog/mrs_pkg.sv ***
// Purpose: types of the microprogram repeat sequencer
// Assumes: mrs_map.svh gives the widths
// Notes:   micro-instruction layout, msb first: ctrl, op, count, addr
`include "mrs_map.svh"

package mrs_pkg;

  // --------------------------------------------------------------------------
  // next-address commands
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_SEQ    = 3'h0,
    OP_SINGLE = 3'h1,
    OP_LDCNT  = 3'h2,
    OP_LOOP   = 3'h3,
    OP_CALL   = 3'h4,
    OP_RET    = 3'h5
  } mrs_op_t;

  // --------------------------------------------------------------------------
  // micro-instruction word
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [`MRS_CTRL_W-1:0] ctrl;
    mrs_op_t                op;
    logic [`MRS_CNT_W-1:0]  count;
    logic [`MRS_ADDR_W-1:0] addr;
  } mrs_uword_t;

endpackage

// *** verilog/mrs_repeat_counter.sv ***
// Purpose: 4-bit repeat counter with all-ones detect
// Assumes: load has priority over increment
// Notes:   holds its value when neither loaded nor incremented
`timescale 1ns/10ps
`include "mrs_map.svh"

module mrs_repeat_counter #(
  parameter int W = `MRS_CNT_W
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         reset,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] loadVal,
  input  wire logic         inc,
  // state
  output logic      [W-1:0] count,
  output logic              detect
);

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;

  assign count_nxt = load ? loadVal : (inc ? W'(count_r + 1'b1) : count_r);
  assign count     = count_r;
  assign detect    = &count_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      count_r <= `MRS_CNT_RST;
    end else begin
      count_r <= count_nxt;
    end
  end

endmodule // mrs_repeat_counter

// *** verilog/mrs_sequencer.sv ***
// Purpose: pipelined microprogram sequencer with single and group repeat, call and return
// Assumes: control store reads addrOut combinationally within the cycle
// Notes:   one level of return address; no register bus
`timescale 1ns/10ps
`include "mrs_map.svh"

module mrs_sequencer (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   reset,
  // control store
  output logic      [`MRS_ADDR_W-1:0] addrOut,
  input  wire mrs_pkg::mrs_uword_t    csWord,
  // system load of the repeat counter
  input  wire logic                   extLoad,
  input  wire logic [`MRS_CNT_W-1:0]  extCount,
  // pipelined outputs
  output logic      [`MRS_CTRL_W-1:0] ctrlOut,
  output logic                        advance,
  output logic                        repDetect,
  output logic      [`MRS_CNT_W-1:0]  repCount
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  mrs_pkg::mrs_uword_t    mir_r;
  mrs_pkg::mrs_uword_t    mir_nxt;
  logic [`MRS_ADDR_W-1:0] upc_r;
  logic [`MRS_ADDR_W-1:0] upc_nxt;
  logic [`MRS_ADDR_W-1:0] save_r;
  logic [`MRS_ADDR_W-1:0] save_nxt;

  // --------------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------------
  function automatic logic isOp(mrs_pkg::mrs_op_t op, mrs_pkg::mrs_op_t want);
    isOp = (op == want);
  endfunction

  wire logic isSingle  = isOp(mir_r.op, mrs_pkg::OP_SINGLE);
  wire logic isLoop    = isOp(mir_r.op, mrs_pkg::OP_LOOP);
  wire logic isCall    = isOp(mir_r.op, mrs_pkg::OP_CALL);
  wire logic isRet     = isOp(mir_r.op, mrs_pkg::OP_RET);
  wire logic csLoads   = isOp(csWord.op, mrs_pkg::OP_SINGLE) | isOp(csWord.op, mrs_pkg::OP_LDCNT);
  // the hold is a feedback mux, never a gated clock, so no clock skew is added
  wire logic stall     = isSingle & ~repDetect;
  wire logic fieldLoad = advance & csLoads;
  wire logic loopStep  = isLoop & ~repDetect;
  wire logic cntLoad   = fieldLoad | extLoad;
  wire logic [`MRS_CNT_W-1:0] cntVal = fieldLoad ? csWord.count : extCount;

  assign advance = ~stall;

  // --------------------------------------------------------------------------
  // next-address multiplexer
  // --------------------------------------------------------------------------
  // loop: repeat address while counting, fall through once detect is up
  wire logic [`MRS_ADDR_W-1:0] loopAddr = repDetect ? upc_r : mir_r.addr;

  always_comb begin
    case (mir_r.op)
      mrs_pkg::OP_LOOP: begin
        addrOut = loopAddr;
      end
      mrs_pkg::OP_CALL: begin
        addrOut = mir_r.addr;
      end
      mrs_pkg::OP_RET: begin
        addrOut = save_r;
      end
      default: begin
        addrOut = upc_r;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // register updates
  // --------------------------------------------------------------------------
  assign mir_nxt  = advance ? csWord : mir_r;
  assign upc_nxt  = advance ? `MRS_ADDR_W'(addrOut + `MRS_ADDR_ONE) : upc_r;
  assign save_nxt = (advance & isCall) ? upc_r : save_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      mir_r  <= '0;
      upc_r  <= `MRS_UPC_RST;
      save_r <= `MRS_SAVE_RST;
    end else begin
      mir_r  <= mir_nxt;
      upc_r  <= upc_nxt;
      save_r <= save_nxt;
    end
  end

  assign ctrlOut = mir_r.ctrl;

  // --------------------------------------------------------------------------
  // repeat counter
  // --------------------------------------------------------------------------
  // single repeat counts every stalled clock, loop counts once per pass
  mrs_repeat_counter #(
    .W (`MRS_CNT_W)
  ) u_counter (
    .mclk    (mclk),
    .reset   (reset),
    .load    (cntLoad),
    .loadVal (cntVal),
    .inc     (stall | loopStep),
    .count   (repCount),
    .detect  (repDetect)
  );

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  logic [4:0] stallRun_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      stallRun_r <= 5'h00;
    end else begin
      stallRun_r <= stall ? 5'(stallRun_r + 5'h01) : 5'h00;
    end
  end

  property p_field_load;
    @(posedge mclk) disable iff (reset)
    fieldLoad |=> repCount == $past(csWord.count);
  endproperty
  a_field_load: assert property (p_field_load) else $error("count not loaded from word");

  property p_detect;
    @(posedge mclk) disable iff (reset)
    repDetect == (repCount == `MRS_CNT_FULL);
  endproperty
  a_detect: assert property (p_detect) else $error("detect mismatch");

  property p_hold;
    @(posedge mclk) disable iff (reset)
    !advance |=> $stable(ctrlOut) && $stable(upc_r);
  endproperty
  a_hold: assert property (p_hold) else $error("registers moved while stalled");

  property p_stall_count;
    @(posedge mclk) disable iff (reset)
    stall && !extLoad |=> repCount == 4'(($past(repCount) + `MRS_CNT_ONE));
  endproperty
  a_stall_count: assert property (p_stall_count) else $error("stall did not count");

  property p_full_runs;
    @(posedge mclk) disable iff (reset)
    isSingle && repDetect |-> advance ##1 (mir_r == $past(csWord));
  endproperty
  a_full_runs: assert property (p_full_runs) else $error("no advance at all ones");

  property p_zero_stall;
    @(posedge mclk) disable iff (reset)
    fieldLoad && !extLoad && isOp(csWord.op, mrs_pkg::OP_SINGLE) && csWord.count == 4'h0
      |=> (!advance)[*8];
  endproperty
  a_zero_stall: assert property (p_zero_stall) else $error("zero load stalled too briefly");

  property p_stall_max;
    @(posedge mclk) disable iff (reset)
    stallRun_r <= 5'h0F;
  endproperty
  a_stall_max: assert property (p_stall_max) else $error("stall longer than 15");

  property p_loop_mux;
    @(posedge mclk) disable iff (reset)
    isLoop && !repDetect |-> addrOut == mir_r.addr;
  endproperty
  a_loop_mux: assert property (p_loop_mux) else $error("loop did not branch back");

  property p_loop_exit;
    @(posedge mclk) disable iff (reset)
    isLoop && repDetect |-> addrOut == upc_r && repCount == `MRS_CNT_FULL;
  endproperty
  a_loop_exit: assert property (p_loop_exit) else $error("loop did not fall through");

  property p_loop_inc;
    @(posedge mclk) disable iff (reset)
    isLoop && !repDetect && !cntLoad |=> repCount == 4'(($past(repCount) + `MRS_CNT_ONE));
  endproperty
  a_loop_inc: assert property (p_loop_inc) else $error("loop did not count");

  property p_ext_load;
    @(posedge mclk) disable iff (reset)
    extLoad && !fieldLoad |=> repCount == $past(extCount);
  endproperty
  a_ext_load: assert property (p_ext_load) else $error("external load lost");

  property p_call_ret;
    @(posedge mclk) disable iff (reset)
    isCall |-> addrOut == mir_r.addr ##1 save_r == $past(upc_r);
  endproperty
  a_call_ret: assert property (p_call_ret) else $error("call did not save return");

  property p_ret;
    @(posedge mclk) disable iff (reset)
    isRet |-> addrOut == save_r;
  endproperty
  a_ret: assert property (p_ret) else $error("return address wrong");

  property p_upc;
    @(posedge mclk) disable iff (reset)
    advance |=> upc_r == 8'(($past(addrOut) + `MRS_ADDR_ONE));
  endproperty
  a_upc: assert property (p_upc) else $error("address counter not plus one");

  property p_cov_stall15;
    @(posedge mclk) disable iff (reset)
    stallRun_r == 5'h0F;
  endproperty
  c_stall15: cover property (p_cov_stall15);

  property p_cov_branch;
    @(posedge mclk) disable iff (reset)
    isLoop && !repDetect;
  endproperty
  c_branch: cover property (p_cov_branch);

  property p_cov_call_ret;
    @(posedge mclk) disable iff (reset)
    isCall ##[1:20] isRet;
  endproperty
  c_call_ret: cover property (p_cov_call_ret);

endmodule // mrs_sequencer

// *** verification/mrs_cstore.sv ***
// Purpose: control store model feeding the sequencer's micro-instruction register
// Assumes: read is combinational within the cycle, as the sequencer expects
// Notes:   ctrl carries 8'hA0 and the address so the bench can tell words apart
`timescale 1ns/10ps
`include "mrs_map.svh"

module mrs_cstore (
  // fetch address
  input  wire logic [`MRS_ADDR_W-1:0] addr,
  // fetched word
  output mrs_pkg::mrs_uword_t         csWord
);
  // --------------------------------------------------------------------------
  // program
  // --------------------------------------------------------------------------
  always_comb begin
    csWord.ctrl  = {8'hA0, addr};
    csWord.op    = mrs_pkg::OP_SEQ;
    csWord.count = 4'h0;
    csWord.addr  = 8'h00;
    case (addr)
      8'h01: begin
        csWord.op = mrs_pkg::OP_SINGLE;
      end
      8'h02: begin
        csWord.op    = mrs_pkg::OP_SINGLE;
        csWord.count = 4'hF;
      end
      // three executions: sixteen minus three
      8'h03: begin
        csWord.op    = mrs_pkg::OP_SINGLE;
        csWord.count = 4'hD;
      end
      8'h04: begin
        csWord.op   = mrs_pkg::OP_CALL;
        csWord.addr = 8'h40;
      end
      8'h41: begin
        csWord.op = mrs_pkg::OP_RET;
      end
      8'h19: begin
        csWord.op    = mrs_pkg::OP_LDCNT;
        csWord.count = 4'hD;
      end
      8'h1C: begin
        csWord.op   = mrs_pkg::OP_LOOP;
        csWord.addr = 8'h1A;
      end
      // one word repeated through the group logic: it loops on itself
      8'h23: begin
        csWord.op    = mrs_pkg::OP_LDCNT;
        csWord.count = 4'hE;
      end
      8'h24: begin
        csWord.op   = mrs_pkg::OP_LOOP;
        csWord.addr = 8'h24;
      end
      default: begin
      end
    endcase
  end
endmodule // mrs_cstore

// *** verification/test_microprogram_repeat_sequencer.sv ***
// Purpose: self-checking bench for the repeat sequencer
// Assumes: program of mrs_cstore; checks sampled at the falling edge
// Notes:   each scenario follows on from the one before it in program order
`timescale 1ns/10ps
`include "mrs_map.svh"

module test_microprogram_repeat_sequencer;
  logic                mclk;
  logic                reset;
  logic                extLoad;
  logic [3:0]          extCount;
  logic [7:0]          addrOut;
  mrs_pkg::mrs_uword_t csWord;
  logic [15:0]         ctrlOut;
  logic                advance;
  logic                repDetect;
  logic [3:0]          repCount;
  int                  failures;
  int                  n_checks;
  int                  k;

  mrs_sequencer dut (.mclk(mclk), .reset(reset), .addrOut(addrOut), .csWord(csWord), .extLoad(extLoad),
                     .extCount(extCount), .ctrlOut(ctrlOut), .advance(advance), .repDetect(repDetect),
                     .repCount(repCount));
  mrs_cstore store (.addr(addrOut), .csWord(csWord));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // --------------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------------
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic see(input logic [7:0] a);
    @(negedge mclk);
    cmp("ctrlOut", {8'hA0, a}, ctrlOut);
  endtask

  task automatic complete_run;
    if (failures == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset;
    @(negedge mclk);
    cmp("ctrlOut", 16'h0000, ctrlOut);
    cmp("repCount", 16'h000F, {12'h000, repCount});
    cmp("addrOut", 16'h0000, {8'h00, addrOut});
  endtask

  // zero count holds the word sixteen cycles, all ones never stalls
  task automatic t_single;
    see(8'h00);
    for (int i = 0; i < 16; i++) begin
      see(8'h01);
      cmp("repCount", 16'(i), {12'h000, repCount});
      cmp("advance", 16'(i == 15), {15'h0000, advance});
      cmp("repDetect", 16'(i == 15), {15'h0000, repDetect});
    end
    see(8'h02);
    cmp("repCount", 16'h000F, {12'h000, repCount});
    repeat (3) see(8'h03);
  endtask

  task automatic t_call;
    see(8'h04);
    cmp("addrOut", 16'h0040, {8'h00, addrOut});
    see(8'h40);
    see(8'h41);
    cmp("addrOut", 16'h0005, {8'h00, addrOut});
    see(8'h05);
  endtask

  // counter steps once per pass and steers the branch at the last step
  task automatic t_loop;
    for (int a = 6; a < 26; a++) begin
      see(8'(a));
      cmp("addrOut", 16'(a + 1), {8'h00, addrOut});
    end
    cmp("repCount", 16'h000D, {12'h000, repCount});
    for (k = 0; k < 20; k++) begin
      see(8'h1A);
      cmp("repCount", {12'h000, 4'hD + 4'(k)}, {12'h000, repCount});
      see(8'h1B);
      see(8'h1C);
      cmp("repCount", {12'h000, 4'hD + 4'(k)}, {12'h000, repCount});
      if (repDetect === 1'b1) begin
        cmp("addrOut", 16'h001D, {8'h00, addrOut});
        break;
      end
      cmp("addrOut", 16'h001A, {8'h00, addrOut});
    end
    if (k == 20) begin
      failures++;
      complete_run();
    end
    see(8'h1D);
  endtask

  task automatic t_ext;
    @(posedge mclk);
    extLoad  <= 1'b1;
    extCount <= 4'h7;
    @(posedge mclk);
    extLoad <= 1'b0;
    @(negedge mclk);
    cmp("repCount", 16'h0007, {12'h000, repCount});
    repeat (3) @(negedge mclk);
    cmp("repCount", 16'h0007, {12'h000, repCount});
  endtask

  // a loop word whose repeat address is its own runs twice for a count of E
  task automatic t_self;
    see(8'h23);
    cmp("repCount", 16'h000E, {12'h000, repCount});
    see(8'h24);
    cmp("repDetect", 16'h0000, {15'h0000, repDetect});
    cmp("addrOut", 16'h0024, {8'h00, addrOut});
    see(8'h24);
    cmp("repDetect", 16'h0001, {15'h0000, repDetect});
    cmp("addrOut", 16'h0025, {8'h00, addrOut});
    see(8'h25);
  endtask

  // reset in mid-run clears the pipeline and restarts at address zero
  task automatic t_rerun;
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    t_reset();
    see(8'h00);
  endtask

  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial begin
    reset    = 1'b1;
    extLoad  = 1'b0;
    extCount = 4'h0;
    failures = 0;
    n_checks = 0;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    t_reset();
    t_single();
    t_call();
    t_loop();
    t_ext();
    t_self();
    t_rerun();
    complete_run();
  end
endmodule // test_microprogram_repeat_sequencer
